// ==== hw/afe_ctl.sv ====
// scanner controller end: Avalon-MM slave that writes and reads the front end registers
// and makes the converter clock ticks and pixel strobes
// assumes one shared clock with the device end
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "afe_regs.svh"
module afe_ctl
#(
	parameter logic [15:0] CONV_DIV_RESET = `AFE_CONV_DIV_RESET, // cycles per tick, minus one
	parameter logic [7:0]  PIX_LEN_RESET  = `AFE_PIX_LEN_RESET   // ticks per pixel
)
(
	input  wire logic        SYS_CLK,          // system clock, 125 MHz
	input  wire logic        RST_N,            // synchronous reset, low
	input  wire logic [4:0]  AVS_ADDRESS,      // byte address
	input  wire logic        AVS_READ,         // read request
	input  wire logic        AVS_WRITE,        // write request
	input  wire logic [31:0] AVS_WRITEDATA,    // write data
	input  wire logic [3:0]  AVS_BYTEENABLE,   // byte lanes
	output logic [31:0]      AVS_READDATA,     // read data
	output logic             AVS_WAITREQUEST,  // slave stall
	afe_if.ctl               LINK              // link to the device
);
	afe_pkg::afe_ctl_state_t state_reg;
	afe_pkg::afe_ctl_state_t state_next;
	logic [31:0]             cur;
	logic [31:0]             wd;

	if (PIX_LEN_RESET == 8'h00)
		$error("pixel length must be at least one tick");

	// reserved device bits are forced low whatever software writes
	function automatic logic [`AFE_REG_W-1:0] clean(input logic [2:0] a, input logic [8:0] d);
		if (a == `AFE_IDX_CFG)
			clean = d & `AFE_CFG_WMASK;
		else if (a == `AFE_IDX_MUX)
			clean = d & `AFE_MUX_WMASK;
		else if (a <= `AFE_IDX_GAIN_B)
			clean = d & `AFE_GAIN_WMASK;
		else
			clean = d & `AFE_OFS_WMASK;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
	endfunction

	always_comb
	begin
		state_next = state_reg;
		cur = '0;
		unique case (AVS_ADDRESS)
			`AFE_CSR_STATUS: cur = {15'h0000, state_reg.rd_pend, 7'h00, state_reg.rd_data};
			`AFE_CSR_TIMING: cur = {16'h0000, state_reg.pix_len, 7'h00, state_reg.run};
			`AFE_CSR_DIV:    cur = {16'h0000, state_reg.div};
			default:         cur = '0;
		endcase
		wd = merge(32'h00000000, AVS_WRITEDATA, AVS_BYTEENABLE);
		state_next.wr_en = 1'b0;
		state_next.rd_en = 1'b0;
		state_next.rd_ack = AVS_READ & ~state_reg.rd_ack;
		state_next.rdata = cur;
		// answer first, so a new read request in the same cycle keeps pending set
		if (LINK.rd_valid)
		begin
			state_next.rd_data = LINK.rd_data;
			state_next.rd_pend = 1'b0;
		end
		if (AVS_WRITE)
		begin
			wd = merge(cur, AVS_WRITEDATA, AVS_BYTEENABLE);
			unique case (AVS_ADDRESS)
				`AFE_CSR_LINK_WR:
				begin
					state_next.wr_en = 1'b1;
					state_next.wr_addr = wd[11:9];
					state_next.wr_data = clean(wd[11:9], wd[8:0]);
				end
				`AFE_CSR_LINK_RD:
				begin
					state_next.rd_en = 1'b1;
					state_next.rd_addr = wd[2:0];
					state_next.rd_pend = 1'b1;
				end
				`AFE_CSR_TIMING:
				begin
					state_next.run = wd[0];
					state_next.pix_len = (wd[15:8] == 8'h00) ? 8'h01 : wd[15:8];
				end
				`AFE_CSR_DIV: state_next.div = wd[15:0];
				default: ;
			endcase
		end
		state_next.conv_tick = 1'b0;
		state_next.pix_strobe = 1'b0;
		if (!state_reg.run)
		begin
			state_next.div_cnt = '0;
			state_next.pix_cnt = '0;
		end
		else if (state_reg.div_cnt >= state_reg.div)
		begin
			state_next.div_cnt = '0;
			state_next.conv_tick = 1'b1;
			// the strobe rides on the first tick of each pixel so red or blue is sampled first
			state_next.pix_strobe = (state_reg.pix_cnt == 8'h00);
			state_next.pix_cnt = (state_reg.pix_cnt + 8'h01 >= state_reg.pix_len) ? 8'h00
				: state_reg.pix_cnt + 8'h01;
		end
		else
			state_next.div_cnt = state_reg.div_cnt + 16'h0001;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			state_reg <= '0;
			state_reg.pix_len <= PIX_LEN_RESET;
			state_reg.div <= CONV_DIV_RESET;
		end
		else
			state_reg <= state_next;
	end

	assign AVS_READDATA = state_reg.rdata;
	assign AVS_WAITREQUEST = AVS_READ & ~state_reg.rd_ack;
	assign LINK.wr_en = state_reg.wr_en;
	assign LINK.wr_addr = state_reg.wr_addr;
	assign LINK.wr_data = state_reg.wr_data;
	assign LINK.rd_en = state_reg.rd_en;
	assign LINK.rd_addr = state_reg.rd_addr;
	assign LINK.converter_clock = state_reg.conv_tick;
	assign LINK.pixel_sample_strobe = state_reg.pix_strobe;
endmodule // afe_ctl

// ==== hw/afe_regs.svh ====
// constants of the imaging front end control block: register indices, fields, resets, timing
// assumes nothing; included by the package and by every module
// Behaviour
// - controller zeroes configuration bits 8, 1, 0
// - configuration bit 7 picks 4 V or 2 V
// - configuration bit 6 enables internal reference, default on
// - configuration bit 5 picks three or one channel
// - configuration bit 4 picks double sampling, default on
// - configuration bit 3 picks 4 V clamp, default
// - bit 2 sleeps, registers kept
// - controller zeroes mux bits 8, 3, 2, 1, 0
// - order bit set: red, green, blue; strobe restarts
// - order bit clear: blue, green, red; strobe restarts
// - single channel: bits 6..4 pick fixed channel
// - separate writable gain register per channel
// - gain is six-bit straight binary, upper zero
// - offset is nine-bit sign magnitude, default zero
// - one channel sample per converter clock tick
// - single channel: only chosen channel is sampled
`ifndef AFE_REGS_SVH
`define AFE_REGS_SVH

`define AFE_REG_W          9
`define AFE_IDX_W          3
// device register indices on the link
`define AFE_IDX_CFG        3'h0
`define AFE_IDX_MUX        3'h1
`define AFE_IDX_GAIN_R     3'h2
`define AFE_IDX_GAIN_G     3'h3
`define AFE_IDX_GAIN_B     3'h4
`define AFE_IDX_OFS_R      3'h5
`define AFE_IDX_OFS_G      3'h6
`define AFE_IDX_OFS_B      3'h7
// configuration fields
`define AFE_CFG_RANGE_4V   7
`define AFE_CFG_REF_INT    6
`define AFE_CFG_THREE_CH   5
`define AFE_CFG_DOUBLE     4
`define AFE_CFG_CLAMP_4V   3
`define AFE_CFG_SLEEP      2
`define AFE_CFG_WMASK      9'h0fc
`define AFE_CFG_RESET      9'h078
// channel order fields
`define AFE_MUX_DIR        7
`define AFE_MUX_RED        6
`define AFE_MUX_GREEN      5
`define AFE_MUX_BLUE       4
`define AFE_MUX_WMASK      9'h0f0
`define AFE_MUX_RESET      9'h0c0
`define AFE_GAIN_WMASK     9'h03f
`define AFE_OFS_WMASK      9'h1ff
`define AFE_ZERO_RESET     9'h000
// controller registers, byte addresses on Avalon-MM
`define AFE_CSR_LINK_WR    5'h00
`define AFE_CSR_LINK_RD    5'h04
`define AFE_CSR_STATUS     5'h08
`define AFE_CSR_TIMING     5'h0c
`define AFE_CSR_DIV        5'h10
`define AFE_STATUS_PEND    16
`define AFE_PIX_LEN_RESET  8'h03
`define AFE_CONV_DIV_RESET 16'h0007

`endif

// ==== hw/afe_pkg.sv ====
// types of the imaging front end control block
// assumes afe_regs.svh beside it
`include "afe_regs.svh"
package afe_pkg;
	typedef enum logic [1:0]
	{
		AFE_CH_RED   = 2'b00,
		AFE_CH_GREEN = 2'b01,
		AFE_CH_BLUE  = 2'b10
	} afe_ch_t;

	typedef struct packed
	{
		logic [1:0] pos;
	} afe_seq_state_t;

	typedef struct packed
	{
		logic [7:0][`AFE_REG_W-1:0] regs;
		logic                       rd_valid;
		logic [`AFE_REG_W-1:0]      rd_data;
		logic                       take;
		afe_ch_t                    ch;
		logic [5:0]                 gain;
		logic [`AFE_REG_W-1:0]      offset;
	} afe_dev_state_t;

	typedef struct packed
	{
		logic                  wr_en;
		logic [`AFE_IDX_W-1:0] wr_addr;
		logic [`AFE_REG_W-1:0] wr_data;
		logic                  rd_en;
		logic [`AFE_IDX_W-1:0] rd_addr;
		logic [`AFE_REG_W-1:0] rd_data;
		logic                  rd_pend;
		logic                  run;
		logic [7:0]            pix_len;
		logic [7:0]            pix_cnt;
		logic [15:0]           div;
		logic [15:0]           div_cnt;
		logic                  conv_tick;
		logic                  pix_strobe;
		logic                  rd_ack;
		logic [31:0]           rdata;
	} afe_ctl_state_t;
endpackage

// ==== hw/afe_if.sv ====
// link between scanner controller and front end: register port plus sampling ticks
// assumes both ends run on one shared clock
`timescale 1ns/1ps
`include "afe_regs.svh"
interface afe_if;
	logic                  wr_en;
	logic [`AFE_IDX_W-1:0] wr_addr;
	logic [`AFE_REG_W-1:0] wr_data;
	logic                  rd_en;
	logic [`AFE_IDX_W-1:0] rd_addr;
	logic                  rd_valid;
	logic [`AFE_REG_W-1:0] rd_data;
	logic                  converter_clock;
	logic                  pixel_sample_strobe;

	modport ctl
	(
		output wr_en, wr_addr, wr_data, rd_en, rd_addr, converter_clock, pixel_sample_strobe,
		input  rd_valid, rd_data
	);
	modport dev
	(
		input  wr_en, wr_addr, wr_data, rd_en, rd_addr, converter_clock, pixel_sample_strobe,
		output rd_valid, rd_data
	);
endinterface

// ==== hw/afe_seq.sv ====
// channel multiplexer sequencer of the front end
// assumes ticks and strobe are one-cycle pulses on clk
`timescale 1ns/1ps
`include "afe_regs.svh"
module afe_seq
(
	input  wire logic             clk,        // system clock
	input  wire logic             rst_n,      // synchronous reset, low
	input  wire logic             conv_tick,  // converter clock tick
	input  wire logic             pix_strobe, // pixel sample strobe
	input  wire logic             three_ch,   // three-channel mode
	input  wire logic             dir_rgb,    // order red first
	input  wire logic [2:0]       single_sel, // red, green, blue select bits
	input  wire logic             sleep,      // no sampling while asleep
	output afe_pkg::afe_ch_t      ch,         // channel sampled now
	output logic                  take        // sample taken this cycle
);
	afe_pkg::afe_seq_state_t state_reg;
	afe_pkg::afe_seq_state_t state_next;
	logic [1:0]              pos_eff;

	function automatic afe_pkg::afe_ch_t order_ch(input logic [1:0] pos, input logic rgb);
		if (pos == 2'h1)
			order_ch = afe_pkg::AFE_CH_GREEN;
		else if ((pos == 2'h0) == rgb)
			order_ch = afe_pkg::AFE_CH_RED;
		else
			order_ch = afe_pkg::AFE_CH_BLUE;
	endfunction

	always_comb
	begin
		state_next = state_reg;
		pos_eff = pix_strobe ? 2'h0 : state_reg.pos;
		take = conv_tick & ~sleep;
		if (three_ch)
			ch = order_ch(pos_eff, dir_rgb);
		// several select bits set: red wins over green over blue; none set falls back to red
		else if (single_sel[2] | ~|single_sel)
			ch = afe_pkg::AFE_CH_RED;
		else if (single_sel[1])
			ch = afe_pkg::AFE_CH_GREEN;
		else
			ch = afe_pkg::AFE_CH_BLUE;
		state_next.pos = pos_eff;
		if (take)
			state_next.pos = (pos_eff == 2'h2) ? 2'h0 : pos_eff + 2'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end
endmodule // afe_seq

// ==== hw/afe_dev.sv ====
// imaging front end: control registers and channel sampling sequence
// assumes the controller end drives the link on the same clock
`timescale 1ns/1ps
`include "afe_regs.svh"
module afe_dev
(
	input  wire logic                  SYS_CLK,        // system clock, 125 MHz
	input  wire logic                  RST_N,          // synchronous reset, low
	afe_if.dev                         LINK,           // link from the controller
	output logic                       RANGE_4V,       // converter range 4 V, else 2 V
	output logic                       REF_INT_EN,     // internal reference enabled
	output logic                       THREE_CH,       // three-channel mode
	output logic                       DOUBLE_SAMPLE,  // double sampling, else sample-hold
	output logic                       CLAMP_4V,       // clamp bias 4 V, else 3 V
	output logic                       SLEEP,          // sleep request active
	output logic                       SAMPLE_TAKE,    // one-cycle pulse per sample
	output afe_pkg::afe_ch_t           SAMPLE_CH,      // channel of that sample
	output logic [5:0]                 SAMPLE_GAIN,    // gain code of that sample
	output logic [`AFE_REG_W-1:0]      SAMPLE_OFFSET   // sign-magnitude offset of that sample
);
	afe_pkg::afe_dev_state_t state_reg;
	afe_pkg::afe_dev_state_t state_next;
	afe_pkg::afe_ch_t        seq_ch;
	logic                    seq_take;
	logic [`AFE_REG_W-1:0]   cfg;
	logic [`AFE_REG_W-1:0]   channel_order_select;

	function automatic logic [`AFE_REG_W-1:0] reset_of(input int idx);
		if (idx == int'(`AFE_IDX_CFG))
			reset_of = `AFE_CFG_RESET;
		else if (idx == int'(`AFE_IDX_MUX))
			reset_of = `AFE_MUX_RESET;
		else
			reset_of = `AFE_ZERO_RESET;
	endfunction

	assign cfg = state_reg.regs[`AFE_IDX_CFG];
	assign channel_order_select = state_reg.regs[`AFE_IDX_MUX];

	afe_seq u_afe_seq
	(
		.clk        (SYS_CLK),
		.rst_n      (RST_N),
		.conv_tick  (LINK.converter_clock),
		.pix_strobe (LINK.pixel_sample_strobe),
		.three_ch   (cfg[`AFE_CFG_THREE_CH]),
		.dir_rgb    (channel_order_select[`AFE_MUX_DIR]),
		.single_sel ({channel_order_select[`AFE_MUX_RED], channel_order_select[`AFE_MUX_GREEN], channel_order_select[`AFE_MUX_BLUE]}),
		.sleep      (cfg[`AFE_CFG_SLEEP]),
		.ch         (seq_ch),
		.take       (seq_take)
	);

	always_comb
	begin
		state_next = state_reg;
		state_next.rd_valid = LINK.rd_en;
		if (LINK.rd_en)
			state_next.rd_data = state_reg.regs[LINK.rd_addr];
		// every register stays writable and unchanged through sleep
		if (LINK.wr_en)
			state_next.regs[LINK.wr_addr] = LINK.wr_data;
		state_next.take = seq_take;
		if (seq_take)
		begin
			// the sample uses values standing before this edge; a write in the same cycle
			// applies from the next sample on
			state_next.ch = seq_ch;
			state_next.gain = state_reg.regs[3'(`AFE_IDX_GAIN_R + seq_ch)][5:0];
			state_next.offset = state_reg.regs[3'(`AFE_IDX_OFS_R + seq_ch)];
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < 8; i++)
				state_reg.regs[i] <= reset_of(i);
			state_reg.rd_valid <= 1'b0;
			state_reg.rd_data <= '0;
			state_reg.take <= 1'b0;
			state_reg.ch <= afe_pkg::AFE_CH_RED;
			state_reg.gain <= '0;
			state_reg.offset <= '0;
		end
		else
			state_reg <= state_next;
	end

	assign LINK.rd_valid = state_reg.rd_valid;
	assign LINK.rd_data = state_reg.rd_data;
	assign RANGE_4V = cfg[`AFE_CFG_RANGE_4V];
	assign REF_INT_EN = cfg[`AFE_CFG_REF_INT];
	assign THREE_CH = cfg[`AFE_CFG_THREE_CH];
	assign DOUBLE_SAMPLE = cfg[`AFE_CFG_DOUBLE];
	assign CLAMP_4V = cfg[`AFE_CFG_CLAMP_4V];
	assign SLEEP = cfg[`AFE_CFG_SLEEP];
	assign SAMPLE_TAKE = state_reg.take;
	assign SAMPLE_CH = state_reg.ch;
	assign SAMPLE_GAIN = state_reg.gain;
	assign SAMPLE_OFFSET = state_reg.offset;
endmodule // afe_dev

// ==== test/afe_link_properties.sv ====
// concurrent checks on the link between controller end and front end
// assumes one clock for both ends; instantiated beside the link interface
`timescale 1ns/1ps
`include "afe_regs.svh"
module afe_link_properties
(
	input wire logic                  SYS_CLK,             // system clock
	input wire logic                  RST_N,               // synchronous reset, low
	input wire logic                  wr_en,               // register write
	input wire logic [`AFE_IDX_W-1:0] wr_addr,             // write index
	input wire logic [`AFE_REG_W-1:0] wr_data,             // write value
	input wire logic                  rd_en,               // register read
	input wire logic [`AFE_IDX_W-1:0] rd_addr,             // read index
	input wire logic                  rd_valid,            // read answer
	input wire logic [`AFE_REG_W-1:0] rd_data,             // read value
	input wire logic                  converter_clock,     // converter tick
	input wire logic                  pixel_sample_strobe  // pixel strobe
);
	logic [`AFE_REG_W-1:0] shadow_reg [8];
	logic [`AFE_REG_W-1:0] shadow_sel;

	// shadow copy lets a read be judged against the last earlier write to its index, or its reset value
	assign shadow_sel = shadow_reg[rd_addr];
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
			shadow_reg <= '{0: `AFE_CFG_RESET, 1: `AFE_MUX_RESET, default: `AFE_ZERO_RESET};
		else if (wr_en)
			shadow_reg[wr_addr] <= wr_data;
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	a_read_answer_next: assert property (rd_en |=> rd_valid) else $error("read unanswered");
	a_answer_has_cause: assert property (rd_valid |-> $past(rd_en)) else $error("stray answer");
	a_read_keeps_value: assert property (rd_en |=> rd_data == $past(shadow_sel))
		else $error("read value differs from last write");
	a_read_data_holds: assert property (!rd_valid |-> $stable(rd_data)) else $error("data moved");
	a_strobe_on_tick: assert property (pixel_sample_strobe |-> converter_clock)
		else $error("strobe without tick");
	a_cfg_zero_bits: assert property (wr_en && wr_addr == `AFE_IDX_CFG |-> wr_data[8] == 1'b0
		&& wr_data[1:0] == 2'h0) else $error("cfg reserved bits set");
	a_mux_zero_bits: assert property (wr_en && wr_addr == `AFE_IDX_MUX |-> wr_data[8] == 1'b0
		&& wr_data[3:0] == 4'h0) else $error("mux reserved bits set");
	a_gain_zero_bits: assert property (wr_en && wr_addr inside {[2:4]} |-> wr_data[8:6] == 3'h0)
		else $error("gain upper bits set");

	c_read: cover property (rd_en ##1 rd_valid);
	c_strobe: cover property (pixel_sample_strobe);
	c_cfg_write: cover property (wr_en && wr_addr == `AFE_IDX_CFG);
endmodule // afe_link_properties

// ==== test/imaging_afe_control_registers_tb_top.sv ====
// self-checking bench: controller and front end joined by the link, driven over Avalon-MM
// assumes the design files under hw/ and the link checker are compiled first
`timescale 1ns/1ps
`include "afe_regs.svh"
module imaging_afe_control_registers_tb_top;
	logic SYS_CLK = 1'b0, RST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
	logic [4:0] AVS_ADDRESS = 5'h00;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, st;
	logic [3:0] AVS_BYTEENABLE = 4'hf;
	logic AVS_WAITREQUEST, RANGE_4V, REF_INT_EN, THREE_CH, DOUBLE_SAMPLE, CLAMP_4V, SLEEP;
	logic SAMPLE_TAKE, tick_d = 1'b0, strb_d = 1'b0, synced = 1'b0, e_three, e_dir, e_sleep = 1'b0;
	afe_pkg::afe_ch_t SAMPLE_CH;
	logic [5:0] SAMPLE_GAIN;
	logic [8:0] SAMPLE_OFFSET;
	logic [1:0] e_single, ec;
	int fail_count = 0, total_checks = 0, pos = 0;
	logic [8:0] wr_t [8] = '{9'h1ff, 9'h1ff, 9'h1c1, 9'h1ea, 9'h1ff, 9'h0ff, 9'h100, 9'h1ff};
	logic [8:0] ex_t [8] = '{9'h0fc, 9'h0f0, 9'h001, 9'h02a, 9'h03f, 9'h0ff, 9'h100, 9'h1ff};
	logic [8:0] rs_t [8] = '{9'h078, 9'h0c0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0};
	logic [8:0] cf_t [6] = '{9'h078, 9'h078, 9'h058, 9'h058, 9'h058, 9'h07c};
	logic [8:0] mx_t [6] = '{9'h0c0, 9'h040, 9'h020, 9'h010, 9'h040, 9'h0c0};

	afe_if u_afe_if ();
	afe_ctl #(.CONV_DIV_RESET(16'h0001), .PIX_LEN_RESET(8'h02)) u_afe_ctl (.SYS_CLK(SYS_CLK),
		.RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINK(u_afe_if));
	afe_dev u_afe_dev (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .LINK(u_afe_if), .RANGE_4V(RANGE_4V),
		.REF_INT_EN(REF_INT_EN), .THREE_CH(THREE_CH), .DOUBLE_SAMPLE(DOUBLE_SAMPLE),
		.CLAMP_4V(CLAMP_4V), .SLEEP(SLEEP), .SAMPLE_TAKE(SAMPLE_TAKE), .SAMPLE_CH(SAMPLE_CH),
		.SAMPLE_GAIN(SAMPLE_GAIN), .SAMPLE_OFFSET(SAMPLE_OFFSET));
	afe_link_properties u_afe_link_properties (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
		.wr_en(u_afe_if.wr_en), .wr_addr(u_afe_if.wr_addr), .wr_data(u_afe_if.wr_data),
		.rd_en(u_afe_if.rd_en), .rd_addr(u_afe_if.rd_addr), .rd_valid(u_afe_if.rd_valid),
		.rd_data(u_afe_if.rd_data), .converter_clock(u_afe_if.converter_clock),
		.pixel_sample_strobe(u_afe_if.pixel_sample_strobe));

	always #4 SYS_CLK = ~SYS_CLK;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic av_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= 1'b1;
		do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
	endtask

	task automatic av_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge SYS_CLK);
		AVS_ADDRESS <= a;
		AVS_READ <= 1'b1;
		do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
		d = AVS_READDATA;
		AVS_READ <= 1'b0;
	endtask

	task automatic dev_wr(input logic [2:0] i, input logic [8:0] v);
		av_write(`AFE_CSR_LINK_WR, {20'h0, i, v});
	endtask

	// status word carries pending flag too, so a stuck read shows up as a mismatch
	task automatic dev_rd(input logic [2:0] i, output logic [31:0] s);
		av_write(`AFE_CSR_LINK_RD, {29'h0, i});
		repeat (3) @(posedge SYS_CLK);
		av_read(`AFE_CSR_STATUS, s);
	endtask

	// four ticks per pixel so the full three-channel order and its wrap are seen
	task automatic run(input logic on);
		av_write(`AFE_CSR_TIMING, {16'h0, 8'h04, 7'h0, on});
		repeat (6) @(posedge SYS_CLK);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// sample watcher: order model restarts only once a strobe has been seen
	always @(posedge SYS_CLK)
	begin
		if (RST_N)
			check(SAMPLE_TAKE, tick_d & ~e_sleep);
		if (RST_N && SAMPLE_TAKE === 1'b1)
		begin
			if (strb_d)
				synced = 1'b1;
			pos = strb_d ? 0 : (pos + 1) % 3;
			ec = !e_three ? e_single : (e_dir ? pos[1:0] : 2'd2 - pos[1:0]);
			if (synced || !e_three)
			begin
				check(SAMPLE_CH, ec);
				check(SAMPLE_GAIN, ex_t[2 + ec][5:0]);
				check(SAMPLE_OFFSET, ex_t[5 + ec]);
			end
		end
		tick_d = u_afe_if.converter_clock;
		strb_d = u_afe_if.pixel_sample_strobe;
	end

	initial
	begin
		repeat (20000) @(posedge SYS_CLK);
		fail_count++;
		print_verdict();
	end

	initial
	begin
		repeat (4) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		check({RANGE_4V, REF_INT_EN, THREE_CH, DOUBLE_SAMPLE, CLAMP_4V, SLEEP}, 6'h1e);
		for (int i = 0; i < 8; i++)
		begin
			dev_rd(i[2:0], st);
			check(st, {23'h0, rs_t[i]});
		end
		for (int i = 0; i < 8; i++)
			dev_wr(i[2:0], wr_t[i]);
		for (int i = 0; i < 8; i++)
		begin
			dev_rd(i[2:0], st);
			check(st, {23'h0, ex_t[i]});
		end
		check({RANGE_4V, REF_INT_EN, THREE_CH, DOUBLE_SAMPLE, CLAMP_4V, SLEEP}, 6'h3f);
		dev_wr(`AFE_IDX_CFG, 9'h000);
		repeat (2) @(posedge SYS_CLK);
		check({RANGE_4V, REF_INT_EN, THREE_CH, DOUBLE_SAMPLE, CLAMP_4V, SLEEP}, 6'h00);
		av_write(`AFE_CSR_DIV, 32'h0001);
		av_read(`AFE_CSR_DIV, st);
		check(st, 32'h0001);
		av_write(5'h14, 32'hffff_ffff);
		av_read(5'h14, st);
		check(st, 32'h0);
		av_read(`AFE_CSR_LINK_WR, st);
		check(st, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			run(1'b0);
			dev_wr(`AFE_IDX_CFG, cf_t[i]);
			dev_wr(`AFE_IDX_MUX, mx_t[i]);
			e_three = cf_t[i][5];
			e_dir = mx_t[i][7];
			e_sleep = cf_t[i][2];
			e_single = mx_t[i][6] ? 2'd0 : mx_t[i][5] ? 2'd1 : 2'd2;
			synced = 1'b0;
			run(1'b1);
			repeat (60) @(posedge SYS_CLK);
			check({RANGE_4V, REF_INT_EN, THREE_CH, DOUBLE_SAMPLE, CLAMP_4V, SLEEP}, cf_t[i][7:2]);
		end
		run(1'b0);
		av_read(`AFE_CSR_TIMING, st);
		check(st, 32'h0400);
		for (int i = 2; i < 8; i++)
		begin
			dev_rd(i[2:0], st);
			check(st, {23'h0, ex_t[i]});
		end
		print_verdict();
	end
endmodule // imaging_afe_control_registers_tb_top
